// ==== cmd_pkg.sv ====
`default_nettype none
package cmd_pkg;
    // mode control field values
    localparam logic [1:0] MODE_RD = 2'h0;
    localparam logic [1:0] MODE_RD_PAUSE = 2'h1;
    localparam logic [1:0] MODE_WR_WORD = 2'h2;
    localparam logic [1:0] MODE_WR_BYTE = 2'h3;
    // register bus map (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    // control register field
    localparam int CTRL_LOCK_BIT = 0;
    localparam logic CTRL_LOCK_RST = 1'b0;
    // status register fields
    localparam int STAT_PAUSE_BIT = 0;
    localparam int STAT_RW_BIT = 1;
    localparam int STAT_MSEL_BIT = 2;
    localparam int STAT_DLY_BIT = 3;
    localparam int STAT_SUPPLY_BIT = 4;
    localparam int STAT_LOCK_BIT = 5;
    localparam int STAT_MODE_LSB = 6;
    // phase lengths: least times round up to whole cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_READ_NS = 200;
    localparam int T_WRITE_NS = 225;
    localparam int READ_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC =
        (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] READ_LAST = 5'(READ_CYC - 1);
    localparam logic [4:0] WRITE_LAST = 5'(WRITE_CYC - 1);
    localparam logic [15:0] WORD_RST = 16'h0000;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CLEAR,
        ST_READ,
        ST_WRITE
    } cmd_state_type;
endpackage
`default_nettype wire

// ==== cmd_mode_decoder.sv ====
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module cmd_mode_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // system bus side
    input wire logic bus_init_b,
    input wire logic dc_lo_b,
    input wire logic dev_start,
    input wire logic [1:0] mode_ctl,
    input wire logic addr_a00,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic data_out_en,
    output logic slave_sync,
    // strap
    input wire logic write_lock_strap,
    // core stack side
    input wire logic [15:0] sense_data,
    output logic [15:0] word_holding_reg,
    output logic load_0,
    output logic load_1,
    output logic clear_0_b,
    output logic clear_1_b,
    output logic strobe_0,
    output logic strobe_1,
    output logic drive_current_window,
    output logic read_phase,
    output logic stack_discharge_en,
    output logic supply_on,
    output logic busy,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    typedef struct packed {
        cmd_pkg::cmd_state_type st;
        logic [4:0] cnt;
        logic [1:0] mode;
        logic a00;
        logic pause;
        logic rw;
        logic msel;
        logic dly;
        logic lock;
        logic [15:0] hold;
        logic ssyn;
        logic [31:0] rdata;
    } cmd_regs_type;

    cmd_regs_type q_r;
    cmd_regs_type q_nxt;
    logic lock_eff;
    logic [1:0] mode_eff;
    logic is_write;
    logic byte_wr;
    logic sel_0;
    logic sel_1;
    logic read_end;
    logic write_end;
    logic ssyn_qual;

    // strap or software lock turns every request into read-restore
    assign lock_eff = write_lock_strap | q_r.lock;
    assign mode_eff = lock_eff ? cmd_pkg::MODE_RD : mode_ctl;

    // decode of the latched transaction
    assign is_write = q_r.mode[1];
    assign byte_wr = (q_r.mode == cmd_pkg::MODE_WR_BYTE);
    assign sel_0 = ~byte_wr | ~q_r.a00;
    assign sel_1 = ~byte_wr | q_r.a00;
    assign read_end = (q_r.st == cmd_pkg::ST_READ) &&
        (q_r.cnt == cmd_pkg::READ_LAST);
    assign write_end = (q_r.st == cmd_pkg::ST_WRITE) &&
        (q_r.cnt == cmd_pkg::WRITE_LAST);

    // byte qualifiers: sense only bytes the master will not supply
    assign read_phase = (q_r.st == cmd_pkg::ST_READ);
    assign strobe_0 = read_end & (~is_write | ~sel_0);
    assign strobe_1 = read_end & (~is_write | ~sel_1);
    assign clear_0_b = ~(q_r.st == cmd_pkg::ST_CLEAR);
    assign clear_1_b = ~(q_r.st == cmd_pkg::ST_CLEAR);
    assign load_0 = (q_r.st == cmd_pkg::ST_WRITE) && (q_r.cnt == 5'h0_0) &&
        is_write && sel_0;
    assign load_1 = (q_r.st == cmd_pkg::ST_WRITE) && (q_r.cnt == 5'h0_0) &&
        is_write && sel_1;
    assign drive_current_window = read_phase |
        (q_r.st == cmd_pkg::ST_WRITE);
    // discharge only pulls the switch node down while writing
    assign stack_discharge_en = drive_current_window &
        ~read_phase;
    // supply cut is combinational: it must act even with logic dead
    assign supply_on = dc_lo_b;
    // reads answer when data is sensed, writes when data is taken
    assign ssyn_qual = (read_end & ~is_write) | (load_0 | load_1);
    assign data_out_en = q_r.ssyn & ~q_r.rw;
    assign bus_rdata = q_r.hold;
    assign word_holding_reg = q_r.hold;
    assign slave_sync = q_r.ssyn;
    assign busy = q_r.msel;
    assign reg_rdata = q_r.rdata;

    // next-state logic for the whole block
    always_comb begin
        q_nxt = q_r;
        q_nxt.ssyn = ssyn_qual;
        q_nxt.rdata = 32'h0000_0000;
        case (q_r.st)
            cmd_pkg::ST_IDLE: begin
                q_nxt.cnt = 5'h0_0;
                if (dev_start) begin
                    q_nxt.mode = mode_eff;
                    q_nxt.a00 = addr_a00;
                    q_nxt.rw = mode_eff[1];
                    q_nxt.msel = 1'b1;
                    q_nxt.dly = 1'b1;
                    // a paused write keeps the earlier read result
                    if (q_r.pause && mode_eff[1]) begin
                        q_nxt.st = cmd_pkg::ST_WRITE;
                    end else begin
                        q_nxt.st = cmd_pkg::ST_CLEAR;
                    end
                end
            end
            cmd_pkg::ST_CLEAR: begin
                q_nxt.hold = cmd_pkg::WORD_RST;
                q_nxt.st = cmd_pkg::ST_READ;
            end
            cmd_pkg::ST_READ: begin
                q_nxt.cnt = q_r.cnt + 5'h0_1;
                if (read_end) begin
                    q_nxt.cnt = 5'h0_0;
                    if (strobe_0) begin
                        q_nxt.hold[7:0] = sense_data[7:0];
                    end
                    if (strobe_1) begin
                        q_nxt.hold[15:8] = sense_data[15:8];
                    end
                    // pause flag is set from the latched mode at the end of the read phase
                    q_nxt.pause = (q_r.mode == cmd_pkg::MODE_RD_PAUSE);
                    if (q_r.mode == cmd_pkg::MODE_RD_PAUSE) begin
                        q_nxt.st = cmd_pkg::ST_IDLE;
                        q_nxt.msel = 1'b0;
                        q_nxt.dly = 1'b0;
                    end else begin
                        q_nxt.st = cmd_pkg::ST_WRITE;
                    end
                end
            end
            cmd_pkg::ST_WRITE: begin
                q_nxt.cnt = q_r.cnt + 5'h0_1;
                if (load_0) begin
                    q_nxt.hold[7:0] = bus_wdata[7:0];
                end
                if (load_1) begin
                    q_nxt.hold[15:8] = bus_wdata[15:8];
                end
                if (write_end) begin
                    q_nxt.cnt = 5'h0_0;
                    q_nxt.st = cmd_pkg::ST_IDLE;
                    q_nxt.pause = 1'b0;
                    q_nxt.msel = 1'b0;
                    q_nxt.dly = 1'b0;
                end
            end
            default: begin
                q_nxt.st = cmd_pkg::ST_IDLE;
            end
        endcase
        // register port: control write, status and data read
        if (reg_wr && (reg_addr == cmd_pkg::REG_CTRL)) begin
            q_nxt.lock = reg_wdata[cmd_pkg::CTRL_LOCK_BIT];
        end
        if (reg_rd) begin
            case (reg_addr)
                cmd_pkg::REG_CTRL: begin
                    q_nxt.rdata[cmd_pkg::CTRL_LOCK_BIT] = q_r.lock;
                end
                cmd_pkg::REG_STAT: begin
                    q_nxt.rdata[cmd_pkg::STAT_PAUSE_BIT] = q_r.pause;
                    q_nxt.rdata[cmd_pkg::STAT_RW_BIT] = q_r.rw;
                    q_nxt.rdata[cmd_pkg::STAT_MSEL_BIT] = q_r.msel;
                    q_nxt.rdata[cmd_pkg::STAT_DLY_BIT] = q_r.dly;
                    q_nxt.rdata[cmd_pkg::STAT_SUPPLY_BIT] = dc_lo_b;
                    q_nxt.rdata[cmd_pkg::STAT_LOCK_BIT] = lock_eff;
                    q_nxt.rdata[cmd_pkg::STAT_MODE_LSB +: 2] = q_r.mode;
                end
                cmd_pkg::REG_DATA: begin
                    q_nxt.rdata[15:0] = q_r.hold;
                end
                default: begin
                    q_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
        // bus init aborts the operation and drops the control flags
        if (!bus_init_b) begin
            q_nxt.st = cmd_pkg::ST_IDLE;
            q_nxt.cnt = 5'h0_0;
            q_nxt.pause = 1'b0;
            q_nxt.rw = 1'b0;
            q_nxt.msel = 1'b0;
            q_nxt.dly = 1'b0;
            q_nxt.ssyn = 1'b0;
        end
    end

    // one register for all state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= '{st: cmd_pkg::ST_IDLE, cnt: 5'h0_0, mode: 2'h0,
                     a00: 1'b0, pause: 1'b0, rw: 1'b0, msel: 1'b0,
                     dly: 1'b0, lock: cmd_pkg::CTRL_LOCK_RST,
                     hold: cmd_pkg::WORD_RST, ssyn: 1'b0,
                     rdata: 32'h0000_0000};
        end else begin
            q_r <= q_nxt;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_rd_restore;
        (q_r.st == cmd_pkg::ST_IDLE) && dev_start && bus_init_b &&
        (mode_eff == cmd_pkg::MODE_RD) && !q_r.pause
        |-> ##22 (q_r.st == cmd_pkg::ST_WRITE) && !load_0 && !load_1;
    endproperty
    a_rd_restore: assert property (p_rd_restore)
        else $error("read-restore did not enter restore without load");

    property p_pause_set;
        (q_r.st == cmd_pkg::ST_IDLE) && dev_start && bus_init_b &&
        (mode_eff == cmd_pkg::MODE_RD_PAUSE) && !q_r.pause
        |-> ##22 q_r.pause && (q_r.st == cmd_pkg::ST_IDLE);
    endproperty
    a_pause_set: assert property (p_pause_set)
        else $error("pause read did not set pause and skip restore");

    property p_word_load;
        (q_r.st == cmd_pkg::ST_WRITE) && (q_r.cnt == 5'h0_0) &&
        (q_r.mode == cmd_pkg::MODE_WR_WORD) |-> load_0 && load_1;
    endproperty
    a_word_load: assert property (p_word_load)
        else $error("word write did not load both bytes");

    property p_byte_hi;
        load_1 && byte_wr && bus_init_b |=> q_r.hold[15:8] ==
            $past(bus_wdata[15:8]) && $stable(q_r.hold[7:0]);
    endproperty
    a_byte_hi: assert property (p_byte_hi)
        else $error("high byte write disturbed low byte");

    property p_byte_lo;
        load_0 && byte_wr |-> !load_1 && !q_r.a00;
    endproperty
    a_byte_lo: assert property (p_byte_lo)
        else $error("low byte write loaded the wrong byte");

    property p_paused_write;
        (q_r.st == cmd_pkg::ST_IDLE) && dev_start && bus_init_b &&
        q_r.pause && mode_eff[1] |=> (q_r.st == cmd_pkg::ST_WRITE);
    endproperty
    a_paused_write: assert property (p_paused_write)
        else $error("paused write did not skip its read");

    property p_lock;
        (q_r.st == cmd_pkg::ST_IDLE) && dev_start && bus_init_b &&
        write_lock_strap |=> !q_r.rw && (q_r.mode == cmd_pkg::MODE_RD);
    endproperty
    a_lock: assert property (p_lock)
        else $error("write lock let a write through");

    property p_discharge;
        read_phase |-> !stack_discharge_en ##1
            (read_phase || !stack_discharge_en ||
             q_r.st == cmd_pkg::ST_WRITE);
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("discharge active during read");

    property p_supply;
        !dc_lo_b |-> !supply_on;
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply not cut on power fail");

    property p_init;
        !bus_init_b |=> !q_r.pause && !q_r.rw && !q_r.msel && !q_r.dly;
    endproperty
    a_init: assert property (p_init)
        else $error("bus init did not clear flags");

    property p_pause_end;
        write_end && bus_init_b |=> !q_r.pause;
    endproperty
    a_pause_end: assert property (p_pause_end)
        else $error("pause survived the paused write");

    c_rd: cover property (read_end && q_r.mode == cmd_pkg::MODE_RD);
    c_pause: cover property (q_r.pause ##[1:100] load_0);
    c_byte: cover property (load_1 && !load_0);
    c_lock: cover property (dev_start && write_lock_strap && mode_ctl[1]);

endmodule
`default_nettype wire

// ==== cmd_bus_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module cmd_bus_master (
    // clock
    input wire logic clk,
    // request side
    output var logic dev_start,
    output var logic [1:0] mode_ctl,
    output var logic addr_a00,
    output var logic [15:0] bus_wdata,
    // answer side
    input wire logic slave_sync,
    input wire logic data_out_en,
    input wire logic busy,
    input wire logic [15:0] bus_rdata
);
    // idle bus at time zero
    initial begin
        dev_start = 1'b0;
        mode_ctl = 2'h0;
        addr_a00 = 1'b0;
        bus_wdata = 16'h0000;
    end

    // one transfer: request for one taking edge, mode and data held until
    // the device drops busy, answer taken where slave_sync stands
    task automatic xfer(input logic [1:0] m, input logic a,
        input logic [15:0] d, output int cyc, output logic oe,
        output logic [15:0] rd);
        int n;
        cyc = 0;
        oe = 1'b0;
        rd = 16'h0000;
        @(posedge clk);
        dev_start <= 1'b1;
        mode_ctl <= m;
        addr_a00 <= a;
        bus_wdata <= d;
        @(posedge clk);
        dev_start <= 1'b0;
        // bounded wait so a silent device cannot hang the master
        // count from the request cycle: the first edge here closes cycle 2
        for (n = 2; n <= 101 && cyc == 0; n++) begin
            @(posedge clk);
            #1;
            if (slave_sync === 1'b1) begin
                cyc = n;
                oe = data_out_en;
                rd = bus_rdata;
            end
        end
        for (n = 0; n < 100 && busy !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        // released data lines must not keep showing the last word
        @(posedge clk);
        bus_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ==== cmd_mode_decoder_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module cmd_mode_decoder_test;
    typedef struct packed {
        logic lock;
        logic [1:0] mode;
        logic a00;
        logic [15:0] wd;
        logic [15:0] hold;
        logic [7:0] cyc;
        logic oe;
        logic [1:0] ld;
    } cmd_row_type;
    localparam logic [15:0] SNS = 16'h5ac3; // word the core stack returns
    // lock, mode, a00, write data, holding reg, sync cycle, out enable, loads
    cmd_row_type rows [7] = '{
        '{1'b0, 2'h0, 1'b0, 16'h1111, SNS, 8'h16, 1'b1, 2'h0},
        '{1'b0, 2'h0, 1'b1, 16'h2222, SNS, 8'h16, 1'b1, 2'h0},
        '{1'b0, 2'h2, 1'b1, 16'h1234, 16'h1234, 8'h17, 1'b0, 2'h3},
        '{1'b0, 2'h3, 1'b1, 16'hbeef, 16'hbec3, 8'h17, 1'b0, 2'h2},
        '{1'b0, 2'h3, 1'b0, 16'hbeef, 16'h5aef, 8'h17, 1'b0, 2'h1},
        '{1'b1, 2'h2, 1'b0, 16'h7777, SNS, 8'h16, 1'b1, 2'h0},
        '{1'b1, 2'h3, 1'b1, 16'h8888, SNS, 8'h16, 1'b1, 2'h0}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic bus_init_b = 1'b1;
    logic dc_lo_b = 1'b1;
    logic write_lock_strap = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire logic dev_start, addr_a00, data_out_en, slave_sync, load_0, load_1;
    wire logic clear_0_b, clear_1_b, strobe_0, strobe_1, busy, supply_on;
    wire logic drive_current_window, read_phase, stack_discharge_en;
    wire logic [1:0] mode_ctl;
    wire logic [15:0] bus_wdata, bus_rdata, word_holding_reg;
    wire logic [31:0] reg_rdata;
    int bad_count = 0;
    int cmp_count = 0;
    int rp_cnt, clr0, clr1, cyc;
    logic [1:0] ld_seen;
    logic [1:0] st_seen;
    logic oe;
    logic [15:0] rd;
    logic [31:0] v;

    always #5 clk = ~clk;

    cmd_mode_decoder uut (.clk(clk), .rst_b(rst_b), .bus_init_b(bus_init_b),
        .dc_lo_b(dc_lo_b), .dev_start(dev_start), .mode_ctl(mode_ctl),
        .addr_a00(addr_a00), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .data_out_en(data_out_en), .slave_sync(slave_sync),
        .write_lock_strap(write_lock_strap), .sense_data(SNS),
        .word_holding_reg(word_holding_reg), .load_0(load_0),
        .load_1(load_1), .clear_0_b(clear_0_b), .clear_1_b(clear_1_b),
        .strobe_0(strobe_0), .strobe_1(strobe_1),
        .drive_current_window(drive_current_window), .read_phase(read_phase),
        .stack_discharge_en(stack_discharge_en), .supply_on(supply_on),
        .busy(busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    cmd_bus_master mst (.clk(clk), .dev_start(dev_start),
        .mode_ctl(mode_ctl), .addr_a00(addr_a00), .bus_wdata(bus_wdata),
        .slave_sync(slave_sync), .data_out_en(data_out_en), .busy(busy),
        .bus_rdata(bus_rdata));

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // register port: strobe one cycle, data stands in the next one only
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] q);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // one transfer with activity counters cleared first
    task automatic go(input logic [1:0] m, input logic a,
        input logic [15:0] d, input int ecyc);
        // step off the edge so the counters' own updates cannot win
        #1;
        rp_cnt = 0;
        st_seen = 2'h0;
        clr0 = 0;
        clr1 = 0;
        ld_seen = 2'h0;
        mst.xfer(m, a, d, cyc, oe, rd);
        check("sync cycle", cyc, ecyc);
    endtask

    // per-op activity; discharge only in the window outside read phase
    always @(posedge clk) begin
        if (rst_b === 1'b1) begin
            rp_cnt <= rp_cnt + int'(read_phase === 1'b1);
            clr0 <= clr0 + int'(clear_0_b === 1'b0);
            clr1 <= clr1 + int'(clear_1_b === 1'b0);
            ld_seen <= ld_seen | {load_1, load_0};
            st_seen <= st_seen | {strobe_1, strobe_0};
            check("discharge", {31'h0, stack_discharge_en},
                {31'h0, drive_current_window & ~read_phase});
        end
    end

    // watchdog: whole run is well under a thousand cycles per transfer
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(cmd_pkg::REG_CTRL, v);
        check("ctrl reset", v, 32'h0000_0000);
        rd_reg(cmd_pkg::REG_STAT, v);
        check("stat reset", v, 32'h0000_0010);
        rd_reg(4'hc, v);
        check("unmapped", v, 32'h0000_0000);
        $display("reset test done");
        foreach (rows[i]) begin
            write_lock_strap <= rows[i].lock;
            go(rows[i].mode, rows[i].a00, rows[i].wd, rows[i].cyc);
            check("hold", word_holding_reg, rows[i].hold);
            check("strobes", st_seen, {30'h0, ~rows[i].ld});
            check("out enable", oe, rows[i].oe);
            check("loads", ld_seen, rows[i].ld);
            check("read cycles", rp_cnt, 20);
            check("clears", {clr0[15:0], clr1[15:0]}, 32'h0001_0001);
            if (rows[i].oe) begin
                check("read data", rd, SNS);
            end
            $display("row %0d done", i);
        end
        write_lock_strap <= 1'b0;
        // soft lock through the control register acts like the strap
        wr_reg(cmd_pkg::REG_CTRL, 32'h0000_0001);
        go(cmd_pkg::MODE_WR_WORD, 1'b0, 16'h0f0f, 22);
        check("soft lock", word_holding_reg, SNS);
        wr_reg(cmd_pkg::REG_CTRL, 32'h0000_0000);
        // pause read then short writes to the same address
        go(cmd_pkg::MODE_RD_PAUSE, 1'b0, 16'h0000, 22);
        check("pause data", rd, SNS);
        rd_reg(cmd_pkg::REG_STAT, v);
        check("pause set", v[cmd_pkg::STAT_PAUSE_BIT], 1);
        go(cmd_pkg::MODE_WR_WORD, 1'b0, 16'h0f0f, 2);
        check("paused word", word_holding_reg, 16'h0f0f);
        rd_reg(cmd_pkg::REG_STAT, v);
        check("pause clear", v[cmd_pkg::STAT_PAUSE_BIT], 0);
        go(cmd_pkg::MODE_RD_PAUSE, 1'b1, 16'h0000, 22);
        go(cmd_pkg::MODE_WR_BYTE, 1'b1, 16'ha1b2, 2);
        check("paused byte", word_holding_reg, 16'ha1c3);
        $display("pause test done");
        // bus init drops a pending pause; next write is a full one
        go(cmd_pkg::MODE_RD_PAUSE, 1'b0, 16'h0000, 22);
        @(posedge clk);
        bus_init_b <= 1'b0;
        @(posedge clk);
        bus_init_b <= 1'b1;
        rd_reg(cmd_pkg::REG_STAT, v);
        check("init flags", v[3:0], 0);
        go(cmd_pkg::MODE_WR_WORD, 1'b0, 16'h3c3c, 23);
        $display("init test done");
        // power fail cuts the generator supply at once
        @(posedge clk);
        dc_lo_b <= 1'b0;
        @(posedge clk);
        #1;
        check("supply off", supply_on, 0);
        rd_reg(cmd_pkg::REG_STAT, v);
        check("supply stat", v[cmd_pkg::STAT_SUPPLY_BIT], 0);
        @(posedge clk);
        dc_lo_b <= 1'b1;
        @(posedge clk);
        #1;
        check("supply on", supply_on, 1);
        $display("power test done");
        end_sim();
    end
endmodule
`default_nettype wire
